// ===== rtl/ldc_pkg.sv
// constants and carrier types for the laser driver control decode
// assumes a serial-interface front end that hands over decoded byte accesses
package ldc_pkg;

  // ***********************************************************
  // register addresses
  // ***********************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00; // control_settings
  localparam logic [7:0] ADDR_MOD = 8'h01; // modulation_current
  localparam logic [7:0] ADDR_BIAS = 8'h02; // bias_current
  localparam logic [7:0] ADDR_EQ = 8'h03; // equalizer_adjust
  localparam logic [7:0] ADDR_MODULATION_RANGE = 8'h0D; // modulation range

  // ***********************************************************
  // control_settings and modulation_range field positions
  // ***********************************************************
  localparam int BIT_CHIP_ON = 7;
  localparam int BIT_PHOTODIODE_RANGE_HI = 6;
  localparam int BIT_PHOTODIODE_RANGE_LO = 5;
  localparam int BIT_OPEN_LOOP = 4;
  localparam int BIT_FAULT_DET = 3;
  localparam int BIT_PEAK_RNG = 2;
  localparam int BIT_EQ_ON = 1;
  localparam int BIT_PD_POL = 0;
  localparam int BIT_MODULATION_RANGE_HI = 1;
  localparam int BIT_MODULATION_RANGE_LO = 0;

  // ***********************************************************
  // reset values (none are defined for the part; all start cleared)
  // ***********************************************************
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_MOD = 8'h00;
  localparam logic [7:0] RST_BIAS = 8'h00;
  localparam logic [7:0] RST_EQ = 8'h00;
  localparam logic [1:0] RST_MODULATION_RANGE = 2'h0;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ***********************************************************
  // current scales, in nA per code step
  // ***********************************************************
  localparam int CUR_W = 26;
  localparam logic [CUR_W-1:0] MOD_STEP_R0_NA = 26'h0016F30; // 94 uA
  localparam logic [CUR_W-1:0] MOD_STEP_R1_NA = 26'h00130B0; // 78 uA
  localparam logic [CUR_W-1:0] MOD_STEP_R2_NA = 26'h000F230; // 62 uA
  localparam logic [CUR_W-1:0] MOD_STEP_R3_NA = 26'h000B798; // 47 uA
  localparam logic [CUR_W-1:0] PD_STEP_NARROW_NA = 26'h00001F4; // 0.5 uA
  localparam logic [CUR_W-1:0] PD_STEP_MID_NA = 26'h00009C4; // 2.5 uA
  localparam logic [CUR_W-1:0] PD_STEP_WIDE_NA = 26'h0001388; // 5 uA
  localparam logic [CUR_W-1:0] OPEN_STEP_NA = 26'h0014FF0; // 86 uA
  localparam int COUPLING_RATIO_DEF = 30; // bias to photodiode ratio

  // ***********************************************************
  // decoded modes
  // ***********************************************************
  typedef enum logic [1:0]
  {
    PD_NARROW = 2'b00,
    PD_MID = 2'b01,
    PD_WIDE = 2'b10
  } ldc_pd_range_e;

  typedef enum logic [0:0]
  {
    LOOP_CLOSED = 1'b0,
    LOOP_OPEN = 1'b1
  } ldc_loop_e;

  // analog control word presented to the current generators
  typedef struct packed
  {
    logic laser_on; // chip on and no latched fault
    logic fault_detect_on; // fault comparators armed
    logic fault_latched; // latched fault condition
    ldc_pd_range_e pd_range; // monitor range
    ldc_loop_e loop_mode; // bias loop mode
    logic peak_wide; // 1: up to 12 mA, 0: up to 6 mA
    logic eq_active; // 0: equalizer bypassed
    logic pd_cathode_vcc; // 1: cathode to supply, 0: anode to ground
    logic [7:0] eq_strength; // 255 = strongest equalization
    logic [CUR_W-1:0] mod_na; // modulation current
    logic [CUR_W-1:0] pd_target_na; // closed loop photodiode target
    logic [CUR_W-1:0] bias_na; // bias current
  } ldc_ctrl_s;

endpackage

// ===== rtl/ldc_decode.sv
// register bank and decode for the laser driver configuration bytes
// assumes byte accesses from the serial front end on clk, plus an async fault pin
//
// Contract
// - chip_on bit 7 runs; low-high clears fault
// - photodiode_range 1X wide, 01 mid, 00 narrow
// - open_loop_select bit 4: open or closed loop
// - fault_detect_on bit 3 gates fault detection
// - peaking_range 1 up to 12mA, 0 up to 6mA
// - equalizer_on bit 1 zero bypasses equalizer
// - photodiode_polarity 1 cathode supply, 0 anode ground
// - modulation step 94/78/62/47 uA by range
// - closed loop bias is ratio times code times step
// - open loop bias is 86 uA times code
// - codes are 8-bit unsigned, bit 7 MSB
// - modulation_range is bits 1:0 at 0x0D
// - equalizer_setting 00 max, FF min equalization
`timescale 1ns/10ps
`default_nettype none

module ldc_decode
#(
  parameter int COUPLING_RATIO = ldc_pkg::COUPLING_RATIO_DEF
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access from the serial front end
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  // fault comparator pin, asynchronous
  input wire logic fault_pin,
  // analog controls
  output var ldc_pkg::ldc_ctrl_s ctrl_ff
);

  // ***********************************************************
  // elaboration checks
  // ***********************************************************
  // ratio times widest step times full code must fit the current width,
  // otherwise the closed loop bias would wrap silently
  if (COUPLING_RATIO < 1
      || COUPLING_RATIO * 255 * int'(ldc_pkg::PD_STEP_WIDE_NA) >= 2 ** ldc_pkg::CUR_W)
  begin : g_bad_ratio
    $error("ldc_decode: COUPLING_RATIO too large for the current width");
  end

  localparam logic [7:0] RATIO = 8'(COUPLING_RATIO);

  // ***********************************************************
  // functions
  // ***********************************************************
  // address match, used by write and read paths
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  // photodiode range decode; the high bit dominates
  function automatic ldc_pkg::ldc_pd_range_e pd_decode(input logic [1:0] f);
    if (f[1])
      pd_decode = ldc_pkg::PD_WIDE;
    else if (f[0])
      pd_decode = ldc_pkg::PD_MID;
    else
      pd_decode = ldc_pkg::PD_NARROW;
  endfunction

  // ***********************************************************
  // stored fields
  // ***********************************************************
  logic [7:0] control_ff; // control_settings
  logic [7:0] mod_code_ff; // modulation_code
  logic [7:0] bias_code_ff; // bias_code
  logic [7:0] eq_setting_ff; // equalizer_setting
  logic [1:0] mod_range_ff; // modulation_range
  logic fault_sync1_ff; // first synchroniser stage
  logic fault_sync2_ff; // second synchroniser stage
  logic fault_ff; // latched fault
  logic chip_on_prev_ff; // chip_on one cycle ago

  // write strobes per register
  logic wr_control;
  logic wr_mod;
  logic wr_bias;
  logic wr_eq;
  logic wr_modulation_range;

  assign wr_control = reg_wr && addr_is(reg_addr, ldc_pkg::ADDR_CONTROL);
  assign wr_mod = reg_wr && addr_is(reg_addr, ldc_pkg::ADDR_MOD);
  assign wr_bias = reg_wr && addr_is(reg_addr, ldc_pkg::ADDR_BIAS);
  assign wr_eq = reg_wr && addr_is(reg_addr, ldc_pkg::ADDR_EQ);
  assign wr_modulation_range = reg_wr && addr_is(reg_addr, ldc_pkg::ADDR_MODULATION_RANGE);

  // ***********************************************************
  // register writes
  // ***********************************************************
  // each field keeps the last byte written (modulation_range only its bits 1:0); unmapped writes are dropped
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      control_ff <= ldc_pkg::RST_CONTROL;
      mod_code_ff <= ldc_pkg::RST_MOD;
      bias_code_ff <= ldc_pkg::RST_BIAS;
      eq_setting_ff <= ldc_pkg::RST_EQ;
      mod_range_ff <= ldc_pkg::RST_MODULATION_RANGE;
    end
    else
    begin
      if (wr_control)
        control_ff <= reg_wdata;
      if (wr_mod)
        mod_code_ff <= reg_wdata;
      if (wr_bias)
        bias_code_ff <= reg_wdata;
      if (wr_eq)
        eq_setting_ff <= reg_wdata;
      if (wr_modulation_range)
        mod_range_ff <= reg_wdata[ldc_pkg::BIT_MODULATION_RANGE_HI:ldc_pkg::BIT_MODULATION_RANGE_LO];
    end
  end

  // ***********************************************************
  // register reads
  // ***********************************************************
  logic [7:0] nxt_rdata; // read mux

  // unused range bits read as zero, unmapped addresses as zero
  always_comb
  begin
    nxt_rdata = ldc_pkg::RDATA_UNMAPPED;
    if (addr_is(reg_addr, ldc_pkg::ADDR_CONTROL))
      nxt_rdata = control_ff;
    else if (addr_is(reg_addr, ldc_pkg::ADDR_MOD))
      nxt_rdata = mod_code_ff;
    else if (addr_is(reg_addr, ldc_pkg::ADDR_BIAS))
      nxt_rdata = bias_code_ff;
    else if (addr_is(reg_addr, ldc_pkg::ADDR_EQ))
      nxt_rdata = eq_setting_ff;
    else if (addr_is(reg_addr, ldc_pkg::ADDR_MODULATION_RANGE))
      nxt_rdata = {6'h00, mod_range_ff};
  end

  // read data held until the next read; valid is a one-cycle pulse
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata_ff <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end
    else
    begin
      reg_rvalid_ff <= reg_rd;
      if (reg_rd)
        reg_rdata_ff <= nxt_rdata;
    end
  end

  // ***********************************************************
  // fault pin synchroniser
  // ***********************************************************
  // only the second stage is read by logic
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fault_sync1_ff <= 1'b0;
      fault_sync2_ff <= 1'b0;
    end
    else
    begin
      fault_sync1_ff <= fault_pin;
      fault_sync2_ff <= fault_sync1_ff;
    end
  end

  // ***********************************************************
  // fault latch
  // ***********************************************************
  logic chip_on; // enable bit
  logic fault_det_on; // detection armed
  logic fault_set; // detection event
  logic fault_clear; // chip_on re-enable edge

  assign chip_on = control_ff[ldc_pkg::BIT_CHIP_ON];
  assign fault_det_on = control_ff[ldc_pkg::BIT_FAULT_DET];
  // a disabled chip has no running laser to fault on
  assign fault_set = fault_sync2_ff && fault_det_on && chip_on;
  // low then high on chip_on is the only way out of a fault
  assign fault_clear = chip_on && !chip_on_prev_ff;

  // set wins over clear, so a fault on the re-enable cycle is kept
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fault_ff <= 1'b0;
      chip_on_prev_ff <= 1'b0;
    end
    else
    begin
      chip_on_prev_ff <= chip_on;
      if (fault_set)
        fault_ff <= 1'b1;
      else if (fault_clear)
        fault_ff <= 1'b0;
    end
  end

  // ***********************************************************
  // current scaling
  // ***********************************************************
  logic [ldc_pkg::CUR_W-1:0] mod_step; // per-code modulation step
  logic [ldc_pkg::CUR_W-1:0] pd_step; // per-code photodiode step
  logic [ldc_pkg::CUR_W-1:0] pd_target; // photodiode target current
  logic [ldc_pkg::CUR_W-1:0] bias_closed; // closed loop bias
  logic [ldc_pkg::CUR_W-1:0] bias_open; // open loop bias
  ldc_pkg::ldc_pd_range_e pd_range; // decoded monitor range

  assign pd_range = pd_decode(control_ff[ldc_pkg::BIT_PHOTODIODE_RANGE_HI:ldc_pkg::BIT_PHOTODIODE_RANGE_LO]);

  // modulation step by range code
  always_comb
  begin
    case (mod_range_ff)
      2'b00: mod_step = ldc_pkg::MOD_STEP_R0_NA;
      2'b01: mod_step = ldc_pkg::MOD_STEP_R1_NA;
      2'b10: mod_step = ldc_pkg::MOD_STEP_R2_NA;
      2'b11: mod_step = ldc_pkg::MOD_STEP_R3_NA;
      default: mod_step = ldc_pkg::MOD_STEP_R0_NA;
    endcase
  end

  // photodiode resolution follows the monitor range
  always_comb
  begin
    case (pd_range)
      ldc_pkg::PD_NARROW: pd_step = ldc_pkg::PD_STEP_NARROW_NA;
      ldc_pkg::PD_MID: pd_step = ldc_pkg::PD_STEP_MID_NA;
      ldc_pkg::PD_WIDE: pd_step = ldc_pkg::PD_STEP_WIDE_NA;
      default: pd_step = ldc_pkg::PD_STEP_NARROW_NA;
    endcase
  end

  // products stay in range: the ratio bound above keeps 5000*255*ratio in 26 bits
  assign pd_target = ldc_pkg::CUR_W'(pd_step * {18'h00000, bias_code_ff});
  assign bias_closed = ldc_pkg::CUR_W'(pd_target * {18'h00000, RATIO});
  assign bias_open = ldc_pkg::CUR_W'(ldc_pkg::OPEN_STEP_NA * {18'h00000, bias_code_ff});

  // ***********************************************************
  // analog control word
  // ***********************************************************
  ldc_pkg::ldc_ctrl_s nxt_ctrl; // next control word
  logic run; // laser driven

  assign run = chip_on && !fault_ff;

  // currents collapse to zero while disabled or faulted
  always_comb
  begin
    nxt_ctrl = '0;
    nxt_ctrl.laser_on = run;
    nxt_ctrl.fault_detect_on = fault_det_on;
    nxt_ctrl.fault_latched = fault_ff;
    nxt_ctrl.pd_range = pd_range;
    nxt_ctrl.loop_mode = control_ff[ldc_pkg::BIT_OPEN_LOOP]
                         ? ldc_pkg::LOOP_OPEN : ldc_pkg::LOOP_CLOSED;
    nxt_ctrl.peak_wide = control_ff[ldc_pkg::BIT_PEAK_RNG];
    nxt_ctrl.eq_active = control_ff[ldc_pkg::BIT_EQ_ON];
    nxt_ctrl.pd_cathode_vcc = control_ff[ldc_pkg::BIT_PD_POL];
    // bypassed equalizer gets no strength at all
    if (control_ff[ldc_pkg::BIT_EQ_ON])
      nxt_ctrl.eq_strength = ~eq_setting_ff;
    else
      nxt_ctrl.eq_strength = 8'h00;
    if (run)
    begin
      nxt_ctrl.mod_na = ldc_pkg::CUR_W'(mod_step * {18'h00000, mod_code_ff});
      if (control_ff[ldc_pkg::BIT_OPEN_LOOP])
      begin
        nxt_ctrl.bias_na = bias_open;
        nxt_ctrl.pd_target_na = '0;
      end
      else
      begin
        nxt_ctrl.bias_na = bias_closed;
        nxt_ctrl.pd_target_na = pd_target;
      end
    end
  end

  // registered so the analog side sees a glitch-free word
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_ff <= '0;
    else
      ctrl_ff <= nxt_ctrl;
  end

endmodule

`default_nettype wire

// ===== test/ldc_decode_properties.sv
// port assertions for the configuration decode
// assumes ldc_pkg is compiled first
`timescale 1ns/10ps
`default_nettype none
// ****
// checker
// ****
module ldc_decode_properties
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // byte access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic reg_rvalid_ff,
  // fault pin and controls
  input wire logic fault_pin,
  input wire ldc_pkg::ldc_ctrl_s ctrl_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic ctl_wr; // control byte taken
  assign ctl_wr = reg_wr && reg_addr == ldc_pkg::ADDR_CONTROL;

  read_answer_a: assert property (reg_rd |=> reg_rvalid_ff)
    else $error("no read answer");
  unmapped_zero_a: assert property (reg_rd && reg_addr > ldc_pkg::ADDR_EQ
    && reg_addr != ldc_pkg::ADDR_MODULATION_RANGE |=> reg_rdata_ff == 8'h00) else $error("unmapped read");
  range_upper_a: assert property (reg_rd && reg_addr == ldc_pkg::ADDR_MODULATION_RANGE
    |=> reg_rdata_ff[7:2] == 6'h00) else $error("range upper bits");
  pd_decode_a: assert property (ctl_wr |-> ##2 ctrl_ff.pd_range ==
    ($past(reg_wdata[6], 2) ? 2'b10 : {1'b0, $past(reg_wdata[5], 2)})) else $error("pd range");
  loop_mode_a: assert property (ctl_wr
    |-> ##2 ctrl_ff.loop_mode == $past(reg_wdata[4], 2)) else $error("loop mode");
  low_bits_a: assert property (ctl_wr
    |-> ##2 {ctrl_ff.fault_detect_on, ctrl_ff.peak_wide, ctrl_ff.eq_active,
    ctrl_ff.pd_cathode_vcc} == $past(reg_wdata[3:0], 2)) else $error("control bits");
  chip_off_a: assert property (ctl_wr && !reg_wdata[7] |-> ##2 !ctrl_ff.laser_on)
    else $error("chip off");
  fault_cause_a: assert property ($rose(ctrl_ff.fault_latched)
    |-> $past(fault_pin, 4) && $past(ctrl_ff.fault_detect_on)) else $error("fault cause");
  fault_kill_a: assert property (ctrl_ff.fault_latched |-> !ctrl_ff.laser_on
    && ctrl_ff.mod_na == '0 && ctrl_ff.bias_na == '0) else $error("fault kill");
endmodule
bind ldc_decode ldc_decode_properties u_ldc_decode_properties
(
  .clk(clk),
  .rst(rst),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata_ff(reg_rdata_ff),
  .reg_rvalid_ff(reg_rvalid_ff),
  .fault_pin(fault_pin),
  .ctrl_ff(ctrl_ff)
);
`default_nettype wire

// ===== test/ldc_host.sv
// host model issuing byte accesses
// assumes the decode answers reads within a few cycles
`timescale 1ns/10ps
`default_nettype none
module ldc_host
(
  // clock
  input wire logic clk,
  // byte access towards the decode
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic reg_rvalid_ff
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one byte; released lines are inverted so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // read with a bounded wait for the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = 1'b0;
    d = 8'h00;
    for (int n = 0; n < 4 && !ok; n++)
    begin
      if (reg_rvalid_ff === 1'b1)
      begin
        ok = 1'b1;
        d = reg_rdata_ff;
      end
      else
      begin
        @(posedge clk);
        #1;
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== test/ldc_decode_test.sv
// self-checking bench for the configuration decode
// assumes the host model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module ldc_decode_test;
  localparam int CR = 30; // coupling ratio under test
  logic clk;
  logic rst;
  logic fault_pin;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_ff;
  logic reg_rvalid_ff;
  ldc_pkg::ldc_ctrl_s ctrl_ff;
  int failures;
  int tests_run;
  always #2.5 clk = ~clk;
  ldc_host u_ldc_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff));
  ldc_decode #(.COUPLING_RATIO(CR)) u_ldc_decode (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff), .fault_pin(fault_pin), .ctrl_ff(ctrl_ff));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // write, then let the control word settle
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    u_ldc_host.wr(a, d);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic get(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_ldc_host.rd(a, d, ok);
    if (!ok)
    begin
      failures++;
      report_and_stop();
    end
    check(32'(d), 32'(exp));
  endtask
  task automatic t_reset();
    get(ldc_pkg::ADDR_CONTROL, ldc_pkg::RST_CONTROL);
    get(ldc_pkg::ADDR_MOD, ldc_pkg::RST_MOD);
    get(ldc_pkg::ADDR_BIAS, ldc_pkg::RST_BIAS);
    get(ldc_pkg::ADDR_EQ, ldc_pkg::RST_EQ);
    get(ldc_pkg::ADDR_MODULATION_RANGE, 8'h00);
    put(8'h05, 8'h5A);
    get(8'h05, ldc_pkg::RDATA_UNMAPPED);
    $display("reset and unmapped done");
  endtask
  task automatic t_ctrl();
    logic [7:0] v [4] = '{8'hE5, 8'hDA, 8'hB5, 8'h8A};
    foreach (v[i])
    begin
      put(ldc_pkg::ADDR_CONTROL, v[i]);
      check(32'(ctrl_ff.pd_range), v[i][6] ? 32'h2 : 32'(v[i][5]));
      check(32'(ctrl_ff.loop_mode), 32'(v[i][4]));
      check(32'(ctrl_ff.fault_detect_on), 32'(v[i][3]));
      check(32'(ctrl_ff.peak_wide), 32'(v[i][2]));
      check(32'(ctrl_ff.eq_active), 32'(v[i][1]));
      check(32'(ctrl_ff.pd_cathode_vcc), 32'(v[i][0]));
      check(32'(ctrl_ff.laser_on), 32'h1);
      get(ldc_pkg::ADDR_CONTROL, v[i]);
    end
    $display("control decode done");
  endtask
  task automatic t_cur();
    logic [31:0] ms [4] = '{94000, 78000, 62000, 47000};
    logic [31:0] ps [3] = '{500, 2500, 5000};
    put(ldc_pkg::ADDR_CONTROL, 8'h80);
    put(ldc_pkg::ADDR_MOD, 8'h81);
    put(ldc_pkg::ADDR_BIAS, 8'hC3);
    for (int r = 0; r < 4; r++)
    begin
      put(ldc_pkg::ADDR_MODULATION_RANGE, 8'hFC | 8'(r));
      check(32'(ctrl_ff.mod_na), 32'h81 * ms[r]);
      get(ldc_pkg::ADDR_MODULATION_RANGE, 8'(r));
    end
    for (int k = 0; k < 3; k++)
    begin
      put(ldc_pkg::ADDR_CONTROL, 8'h80 | 8'(k << 5));
      check(32'(ctrl_ff.bias_na), CR * 32'hC3 * ps[k]);
      check(32'(ctrl_ff.pd_target_na), 32'hC3 * ps[k]);
    end
    put(ldc_pkg::ADDR_CONTROL, 8'h90);
    check(32'(ctrl_ff.bias_na), 32'hC3 * 86000);
    check(32'(ctrl_ff.pd_target_na), 32'h0);
    put(ldc_pkg::ADDR_CONTROL, 8'h82);
    put(ldc_pkg::ADDR_EQ, 8'h00);
    check(32'(ctrl_ff.eq_strength), 32'hFF);
    put(ldc_pkg::ADDR_EQ, 8'hFF);
    check(32'(ctrl_ff.eq_strength), 32'h00);
    put(ldc_pkg::ADDR_CONTROL, 8'h00);
    check(32'(ctrl_ff.laser_on), 32'h0);
    check(32'(ctrl_ff.mod_na), 32'h0);
    check(32'(ctrl_ff.bias_na), 32'h0);
    put(ldc_pkg::ADDR_EQ, 8'h00);
    check(32'(ctrl_ff.eq_strength), 32'h00);
    $display("currents done");
  endtask
  task automatic t_fault();
    put(ldc_pkg::ADDR_CONTROL, 8'h80);
    fault_pin = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check(32'(ctrl_ff.fault_latched), 32'h0);
    put(ldc_pkg::ADDR_CONTROL, 8'h88);
    repeat (4) @(posedge clk);
    #1;
    check(32'(ctrl_ff.fault_latched), 32'h1);
    check(32'(ctrl_ff.laser_on), 32'h0);
    fault_pin = 1'b0;
    put(ldc_pkg::ADDR_CONTROL, 8'h08);
    put(ldc_pkg::ADDR_CONTROL, 8'h88);
    check({31'h0, ctrl_ff.fault_latched}, 32'h0);
    check({31'h0, ctrl_ff.laser_on}, 32'h1);
    $display("fault done");
  endtask
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    fault_pin = 1'b0;
    failures = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_ctrl();
    t_cur();
    t_fault();
    report_and_stop();
  end
endmodule
`default_nettype wire
